// [emi_consts.vh]
/*
 * Constants for the external memory interface: config register layout,
 * reset values, memory modes and on-chip memory sizes.
 * Assumes inclusion by bare name from the emi design files.
 */
`ifndef EMI_CONSTS_VH
`define EMI_CONSTS_VH

// Config register layout
`define EMI_CFG_RESET 8'h03
`define EMI_CFG_WMASK 8'h5f
`define EMI_CFG_MUX_BIT 4
`define EMI_CFG_MODE_HI 3
`define EMI_CFG_MODE_LO 2
`define EMI_CFG_ALE_HI 1
`define EMI_CFG_ALE_LO 0

// Memory modes
`define EMI_MODE_INTERNAL 2'h0
`define EMI_MODE_SPLIT_NOBANK 2'h1
`define EMI_MODE_SPLIT_BANK 2'h2
`define EMI_MODE_EXTERNAL 2'h3

// On-chip sizes and the bank-select boundary
`define EMI_SIZE_2K 16'h0800
`define EMI_SIZE_4K 16'h1000
`define EMI_BOUND_8K 16'h2000

// Page select reset
`define EMI_PAGE_RESET 8'h00

// Fixed overhead cycles of an off-chip access
`define EMI_ACCESS_OVERHEAD 3'h4

`endif

// [emi_addr_decode.v]
/*
 * Effective address formation and on-chip/off-chip routing for external moves.
 * Assumes same-clock inputs from the CPU; purely combinational.
 */
`timescale 1ns/1ps
`include "emi_consts.vh"

module emi_addr_decode (
   // Configuration
   input wire [1:0] memoryModeField,
   input wire bigRam,
   input wire [7:0] pageSelect,
   // Request
   input wire wideMove,
   input wire [15:0] dataPointer,
   input wire [7:0] indexValue,
   // Result
   output reg offChip,
   output reg [15:0] effAddr,
   output reg [15:0] onChipAddr,
   output reg driveHigh
);

   reg [15:0] boundary;
   reg [15:0] narrowAddr;

   ////////////////////////////////////////////////////////////////////////
   // Address, route and upper-byte drive
   always @*
   begin
      boundary = bigRam ? `EMI_SIZE_4K : `EMI_SIZE_2K;
      narrowAddr = {pageSelect, indexValue};
      effAddr = wideMove ? dataPointer : narrowAddr;
      offChip = 1'b0;
      driveHigh = 1'b1;
      // Wrap keeps on-chip index inside populated memory
      onChipAddr = effAddr & (boundary - 16'h0001);
      case (memoryModeField)
         `EMI_MODE_INTERNAL:
         begin
            offChip = 1'b0;
         end
         `EMI_MODE_SPLIT_NOBANK:
         begin
            // Equal to the size is already off-chip
            offChip = (effAddr >= boundary);
            driveHigh = wideMove;
         end
         `EMI_MODE_SPLIT_BANK:
         begin
            offChip = (effAddr >= `EMI_BOUND_8K);
            driveHigh = 1'b1;
         end
         default:
         begin
            offChip = 1'b1;
            driveHigh = wideMove;
            if (!wideMove)
            begin
               effAddr = {8'h00, indexValue};
            end
         end
      endcase
   end

endmodule // emi_addr_decode

// [emi_phase_timer.v]
/*
 * Down counter that times one bus phase in system clock cycles.
 * Assumes a load pulse and a length of at least one cycle.
 */
`timescale 1ns/1ps

module emi_phase_timer (
   // Clocking
   input wire clk,
   input wire reset,
   input wire clkEn,
   // Control
   input wire load,
   input wire [2:0] length,
   // Status
   output wire done
);

   reg [2:0] count_reg;

   ////////////////////////////////////////////////////////////////////////
   // Count down to one, then report done
   always @(posedge clk or posedge reset)
   begin
      if (reset)
         count_reg <= 3'h1;
      else if (clkEn)
      begin
         if (load)
            count_reg <= length;
         else if (count_reg != 3'h1)
            count_reg <= count_reg - 3'h1;
      end
   end

   assign done = (count_reg == 3'h1);

endmodule // emi_phase_timer

// [emi_ext_mem_if.v]
/*
 * External memory interface top: config and page select registers,
 * address routing, and the off-chip bus sequencer for muxed and
 * separate address/data pin forms.
 * Assumes a CPU that raises moveStart for one cycle and waits for
 * moveDone; register writes come from the same clock domain; the read
 * data pins come from outside and are synchronised.
 */
// How it works
// - Config bit 4 picks muxed or separate bus
// - Muxed: data and low address share pins
// - Latch strobe high while low address shown
// - After strobe falls, pins carry data
// - Strobe high and low each 1-4 cycles
// - Separate form: address and data on own pins
// - Mode 00: all on-chip, wrapping at size
// - Internal 8-bit address: page high, index low
// - Internal 16-bit address from data pointer
// - Mode 01: below size on-chip, else off
// - Split 8-bit route decided by page select
// - No-bank 8-bit: upper pins undriven, index low
// - Split 16-bit: pointer routes, all pins driven
// - Mode 10: below 8k on-chip, else off
// - Bank select 8-bit: page high, index low
// - Mode 11: all off-chip, on-chip invisible
// - External 8-bit: ignore page, upper undriven
// - External 16-bit: pointer address, all pins
`timescale 1ns/1ps
`include "emi_consts.vh"

module emi_ext_mem_if (
   // Clocking
   input wire clk,
   input wire reset,
   input wire clkEn,
   // Register port
   input wire cfgWrite,
   input wire pageWrite,
   input wire [7:0] regWData,
   output wire [7:0] extMemConfigReg,
   output wire [7:0] pageSelectReg,
   // Device option
   input wire bigRam,
   // External move request
   input wire moveStart,
   input wire moveWrite,
   input wire wideMove,
   input wire [15:0] dataPointer,
   input wire [7:0] indexValue,
   input wire [7:0] moveWData,
   output wire moveDone,
   output reg [7:0] moveRData,
   // On-chip memory port
   output reg onChipSel,
   output reg [15:0] onChipAddr,
   // Address pins
   output reg [15:0] addrOut,
   output reg addrHighOe,
   output reg addrLowOe,
   // Shared or data pins
   output reg [7:0] adOut,
   input wire [7:0] adIn,
   output reg adOe,
   // Strobes
   output reg latchStrobe,
   output reg readStrobeN,
   output reg writeStrobeN
);

   // Sequencer states
   localparam ST_IDLE = 3'h0;
   localparam ST_ALE_HIGH = 3'h1;
   localparam ST_ALE_LOW = 3'h2;
   localparam ST_STROBE = 3'h3;
   localparam ST_TAIL = 3'h4;
   localparam ST_ONCHIP = 3'h5;

   reg [7:0] cfg_reg;
   reg [7:0] page_reg;
   reg [2:0] state_reg;
   reg [2:0] state_next;
   reg [7:0] adSync1_reg;
   reg [7:0] adSync2_reg;
   reg [7:0] wData_reg;
   reg write_reg;
   reg [15:0] ea_reg;
   reg highOe_reg;
   reg timerLoad;
   reg [2:0] timerLen;
   reg done_reg;

   wire muxedBusSelect;
   wire [1:0] memoryModeField;
   wire [1:0] latchStrobeWidthField;
   wire [2:0] aleCycles;
   wire decOffChip;
   wire [15:0] decAddr;
   wire [15:0] decOnChipAddr;
   wire decDriveHigh;
   wire timerDone;

   ////////////////////////////////////////////////////////////////////////
   // Config and page select registers

   assign muxedBusSelect = ~cfg_reg[`EMI_CFG_MUX_BIT];
   assign memoryModeField = cfg_reg[`EMI_CFG_MODE_HI:`EMI_CFG_MODE_LO];
   assign latchStrobeWidthField = cfg_reg[`EMI_CFG_ALE_HI:`EMI_CFG_ALE_LO];
   // Code 00..11 gives 1..4 cycles
   assign aleCycles = {1'b0, latchStrobeWidthField} + 3'h1;
   assign extMemConfigReg = cfg_reg;
   assign pageSelectReg = page_reg;

   // Unused bits 7 and 5 read as zero
   always @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         cfg_reg <= `EMI_CFG_RESET;
         page_reg <= `EMI_PAGE_RESET;
      end
      else if (clkEn)
      begin
         if (cfgWrite)
            cfg_reg <= regWData & `EMI_CFG_WMASK;
         if (pageWrite)
            page_reg <= regWData;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Address routing

   emi_addr_decode u_decode (
      .memoryModeField(memoryModeField),
      .bigRam(bigRam),
      .pageSelect(page_reg),
      .wideMove(wideMove),
      .dataPointer(dataPointer),
      .indexValue(indexValue),
      .offChip(decOffChip),
      .effAddr(decAddr),
      .onChipAddr(decOnChipAddr),
      .driveHigh(decDriveHigh)
   );

   ////////////////////////////////////////////////////////////////////////
   // Phase timer

   emi_phase_timer u_timer (
      .clk(clk),
      .reset(reset),
      .clkEn(clkEn),
      .load(timerLoad),
      .length(timerLen),
      .done(timerDone)
   );

   ////////////////////////////////////////////////////////////////////////
   // Read pins come from outside: two-stage synchroniser
   always @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         adSync1_reg <= 8'h00;
         adSync2_reg <= 8'h00;
      end
      else if (clkEn)
      begin
         adSync1_reg <= adIn;
         adSync2_reg <= adSync1_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sequencer next state and timer control
   always @*
   begin
      state_next = state_reg;
      timerLoad = 1'b0;
      timerLen = 3'h1;
      case (state_reg)
         ST_IDLE:
         begin
            if (moveStart)
            begin
               timerLoad = 1'b1;
               if (!decOffChip)
               begin
                  state_next = ST_ONCHIP;
               end
               else if (muxedBusSelect)
               begin
                  timerLen = aleCycles;
                  state_next = ST_ALE_HIGH;
               end
               else
               begin
                  state_next = ST_STROBE;
               end
            end
         end
         ST_ALE_HIGH:
         begin
            if (timerDone)
            begin
               timerLoad = 1'b1;
               timerLen = aleCycles;
               state_next = ST_ALE_LOW;
            end
         end
         ST_ALE_LOW:
         begin
            if (timerDone)
            begin
               timerLoad = 1'b1;
               state_next = ST_STROBE;
            end
         end
         ST_STROBE:
         begin
            if (timerDone)
            begin
               timerLoad = 1'b1;
               timerLen = `EMI_ACCESS_OVERHEAD;
               state_next = ST_TAIL;
            end
         end
         ST_TAIL:
         begin
            if (timerDone)
               state_next = ST_IDLE;
         end
         ST_ONCHIP:
         begin
            state_next = ST_IDLE;
         end
         default:
         begin
            state_next = ST_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Request capture and state register
   // Route, address, upper drive and write data are frozen at start, but a config write
   // mid-access still changes the latch strobe low width, read live when that phase loads.
   always @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         state_reg <= ST_IDLE;
         wData_reg <= 8'h00;
         write_reg <= 1'b0;
         ea_reg <= 16'h0000;
         highOe_reg <= 1'b0;
         done_reg <= 1'b0;
      end
      else if (clkEn)
      begin
         state_reg <= state_next;
         done_reg <= ((state_reg == ST_TAIL) && timerDone) || (state_reg == ST_ONCHIP);
         if ((state_reg == ST_IDLE) && moveStart)
         begin
            wData_reg <= moveWData;
            write_reg <= moveWrite;
            ea_reg <= decAddr;
            highOe_reg <= decDriveHigh;
         end
      end
   end

   assign moveDone = done_reg;

   ////////////////////////////////////////////////////////////////////////
   // Pin drivers, registered
   always @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         addrOut <= 16'h0000;
         addrHighOe <= 1'b0;
         addrLowOe <= 1'b0;
         adOut <= 8'h00;
         adOe <= 1'b0;
         latchStrobe <= 1'b0;
         readStrobeN <= 1'b1;
         writeStrobeN <= 1'b1;
         onChipSel <= 1'b0;
         onChipAddr <= 16'h0000;
         moveRData <= 8'h00;
      end
      else if (clkEn)
      begin
         latchStrobe <= 1'b0;
         readStrobeN <= 1'b1;
         writeStrobeN <= 1'b1;
         onChipSel <= 1'b0;
         // Read data taken at the tail end, past the synchroniser delay
         if ((state_reg == ST_TAIL) && timerDone && !write_reg)
            moveRData <= adSync2_reg;
         case (state_next)
            ST_ALE_HIGH:
            begin
               // Low address on shared pins while the latch is open
               // Later cycles of the phase use the captured address, not live inputs
               latchStrobe <= 1'b1;
               adOut <= (state_reg == ST_IDLE) ? decAddr[7:0] : ea_reg[7:0];
               adOe <= 1'b1;
               addrOut <= (state_reg == ST_IDLE) ? {decAddr[15:8], 8'h00} : {ea_reg[15:8], 8'h00};
               addrHighOe <= (state_reg == ST_IDLE) ? decDriveHigh : highOe_reg;
               addrLowOe <= 1'b0;
            end
            ST_ALE_LOW:
            begin
               // Latch now holds; a write puts its data on the pins, a read releases them
               adOut <= write_reg ? wData_reg : adOut;
               adOe <= write_reg;
            end
            ST_STROBE:
            begin
               // Data owns the pins by the time a strobe asserts
               adOut <= (state_reg == ST_IDLE) ? moveWData : wData_reg;
               adOe <= (state_reg == ST_IDLE) ? moveWrite : write_reg;
               if (state_reg == ST_IDLE)
               begin
                  addrOut <= decAddr;
                  addrHighOe <= decDriveHigh;
                  addrLowOe <= 1'b1;
                  readStrobeN <= moveWrite;
                  writeStrobeN <= ~moveWrite;
               end
               else
               begin
                  readStrobeN <= write_reg;
                  writeStrobeN <= ~write_reg;
               end
            end
            ST_TAIL:
            begin
               // Pins hold their values through the tail
            end
            ST_ONCHIP:
            begin
               onChipSel <= 1'b1;
               onChipAddr <= decOnChipAddr;
            end
            default:
            begin
               adOe <= 1'b0;
               addrHighOe <= 1'b0;
               addrLowOe <= 1'b0;
            end
         endcase
      end
   end

endmodule // emi_ext_mem_if

// [emi_ext_mem_if_sva.sv]
/* Checker for the external memory interface top.
   Assumes one clock domain and a CPU that waits for moveDone. */
`timescale 1ns/1ps

module emi_ext_mem_if_sva (
   // Clocking
   input wire clk,
   input wire reset,
   input wire clkEn,
   // Registers and request
   input wire [7:0] extMemConfigReg,
   input wire [7:0] pageSelectReg,
   input wire bigRam,
   input wire moveStart,
   input wire wideMove,
   input wire [15:0] dataPointer,
   input wire [7:0] indexValue,
   input wire [7:0] moveWData,
   input wire moveDone,
   // Memory side
   input wire onChipSel,
   input wire [15:0] onChipAddr,
   input wire [15:0] addrOut,
   input wire addrHighOe,
   input wire addrLowOe,
   input wire [7:0] adOut,
   input wire adOe,
   input wire latchStrobe,
   input wire readStrobeN,
   input wire writeStrobeN
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   reg busy_reg;
   reg wide_reg;
   reg [15:0] ea_reg;
   reg [7:0] wd_reg;
   reg [2:0] hiCnt_reg;
   reg [2:0] loCnt_reg;
   wire taken = clkEn && moveStart && (!busy_reg || moveDone);
   wire [1:0] mode = extMemConfigReg[3:2];
   wire [2:0] alen = {1'b0, extMemConfigReg[1:0]} + 3'h1;
   wire strobe = !readStrobeN || !writeStrobeN;
   wire [15:0] size = bigRam ? 16'h1000 : 16'h0800;
   wire [15:0] eaNow = wideMove ? dataPointer : {pageSelectReg, indexValue};
   wire onNow = mode == 2'h0 || mode != 2'h3 && eaNow < (mode == 2'h2 ? 16'h2000 : size);
   ////////////////////////////////////////
   // Request capture and phase counters, so later phases tie to their cause
   always @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         busy_reg <= 1'b0;
         wide_reg <= 1'b0;
         ea_reg <= 16'h0000;
         wd_reg <= 8'h00;
         hiCnt_reg <= 3'h0;
         loCnt_reg <= 3'h0;
      end
      else if (clkEn)
      begin
         busy_reg <= taken || busy_reg && !moveDone;
         if (taken)
         begin
            wide_reg <= wideMove;
            ea_reg <= eaNow;
            wd_reg <= moveWData;
         end
         hiCnt_reg <= latchStrobe ? hiCnt_reg + 3'h1 : 3'h0;
         loCnt_reg <= (latchStrobe || strobe) ? 3'h0 : loCnt_reg + 3'h1;
      end
   end
   ////////////////////////////////////////
   // Strobe, then four idle tail cycles, then done
   sequence tailDone;
      !strobe [*4] ##1 moveDone;
   endsequence
   a_strobe_tail_done: assert property ($fell(readStrobeN && writeStrobeN) |=> tailDone)
      else $error("strobe tail length wrong");
   a_ale_high_width: assert property ($fell(latchStrobe) |-> hiCnt_reg == alen)
      else $error("latch strobe high phase wrong");
   a_ale_low_width: assert property ($fell(readStrobeN && writeStrobeN) && !extMemConfigReg[4]
      |-> loCnt_reg == alen)
      else $error("latch strobe low phase wrong");
   a_ale_low_addr: assert property (latchStrobe |-> adOe && adOut == ea_reg[7:0])
      else $error("low address not on shared pins");
   a_write_data_pins: assert property (!writeStrobeN |-> adOe && adOut == wd_reg && !latchStrobe)
      else $error("write data not on pins");
   a_sep_own_pins: assert property (extMemConfigReg[4] |-> !latchStrobe
      && (!strobe || addrLowOe && addrOut[7:0] == ea_reg[7:0]))
      else $error("separate form pins wrong");
   a_wide_all_pins: assert property (strobe && wide_reg |-> addrHighOe
      && addrOut[15:8] == ea_reg[15:8] && (!extMemConfigReg[4] || addrOut[7:0] == ea_reg[7:0]))
      else $error("wide move address pins wrong");
   a_narrow_high_byte: assert property (strobe && !wide_reg |-> addrHighOe == (mode == 2'h2)
      && (mode != 2'h2 || addrOut[15:8] == ea_reg[15:8]))
      else $error("narrow move upper pins wrong");
   a_onchip_then_done: assert property (onChipSel |=> moveDone)
      else $error("on-chip move not done in time");
   a_route_by_mode: assert property (taken |=> onChipSel == $past(onNow))
      else $error("move routed to wrong space");
   a_onchip_wrap: assert property (onChipSel |-> onChipAddr == (ea_reg & (size - 16'h0001)))
      else $error("on-chip address wrong");
endmodule // emi_ext_mem_if_sva

bind emi_ext_mem_if emi_ext_mem_if_sva emi_ext_mem_if_sva_i (.*);

// [emi_sram_model.sv]
/* Behavioural parallel SRAM with a transparent address latch.
   Assumes the board ties unshared upper pins to the port latch value. */
`timescale 1ns/1ps

module emi_sram_model (
   // Bus pins
   input wire clk,
   input wire muxed,
   input wire [7:0] portHigh,
   input wire [15:0] addrOut,
   input wire addrHighOe,
   input wire [7:0] adOut,
   input wire latchStrobe,
   input wire readStrobeN,
   input wire writeStrobeN,
   // Read data and last address seen
   output wire [7:0] adIn,
   output reg [15:0] lastAddr
);
   reg [7:0] mem [0:65535];
   reg [7:0] latchQ;
   reg [2:0] holdCnt_reg = 3'h0;
   wire [15:0] addr = {addrHighOe ? addrOut[15:8] : portHigh, muxed ? latchQ : addrOut[7:0]};
   // Latch follows while strobe high, holds after it falls; sampled mid-cycle
   // so the strobe fall and the data switch never race
   always @(negedge clk)
      if (latchStrobe)
         latchQ <= adOut;
   // Writes on strobe; read data held for the five cycles after the read strobe
   always @(posedge clk)
   begin
      holdCnt_reg <= holdCnt_reg == 3'h0 ? 3'h0 : holdCnt_reg - 3'h1;
      if (!writeStrobeN)
      begin
         mem[addr] <= adOut;
         lastAddr <= addr;
      end
      if (!readStrobeN)
      begin
         holdCnt_reg <= 3'h5;
         lastAddr <= addr;
      end
   end
   // Released pins show the inverse, never a stale copy
   assign adIn = (!readStrobeN || holdCnt_reg != 3'h0) ? mem[addr] : ~mem[addr];
endmodule // emi_sram_model

// [test_emi_ext_mem_if.sv]
/* Self-checking bench for the external memory interface top.
   Assumes the SRAM model on the pins; clkEn high except in the freeze check. */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
   $display("wrong value %s exp %h got %h", nm, e, g); end end

module test_emi_ext_mem_if;
   reg clk = 1'b0, reset = 1'b1, clkEn = 1'b1, cfgWrite = 1'b0, pageWrite = 1'b0, bigRam = 1'b0;
   reg moveStart = 1'b0, moveWrite = 1'b0, wideMove = 1'b0;
   reg [7:0] regWData = 8'h00, indexValue = 8'h00, moveWData = 8'h00, portHigh = 8'h77;
   reg [15:0] dataPointer = 16'h0000;
   wire [7:0] extMemConfigReg, pageSelectReg, moveRData, adOut, adIn;
   wire [15:0] onChipAddr, addrOut, lastAddr;
   wire moveDone, onChipSel, addrHighOe, addrLowOe, adOe, latchStrobe, readStrobeN, writeStrobeN;
   wire muxed = !extMemConfigReg[4];
   int fails = 0, n_checks = 0, n;
   reg sel;
   reg [15:0] oa;
   always #12.5 clk = ~clk;
   emi_ext_mem_if emi_ext_mem_if_i (.*);
   emi_sram_model emi_sram_model_i (.*);
   ////////////////////////////////////////
   // Register write: one cycle pulse
   task wr_reg(input bit page, input [7:0] v);
      @(posedge clk);
      cfgWrite <= !page;
      pageWrite <= page;
      regWData <= v;
      @(posedge clk);
      cfgWrite <= 1'b0;
      pageWrite <= 1'b0;
   endtask
   // One move; counts cycles from the taking edge to moveDone
   task move(input w, input wd, input [15:0] a, input [7:0] d);
      @(posedge clk);
      moveStart <= 1'b1;
      moveWrite <= w;
      wideMove <= wd;
      dataPointer <= a;
      indexValue <= a[7:0];
      moveWData <= d;
      @(posedge clk);
      moveStart <= 1'b0;
      n = 0;
      sel = 1'b0;
      do
      begin
         @(negedge clk);
         n++;
         if (onChipSel === 1'b1)
         begin
            sel = 1'b1;
            oa = onChipAddr;
         end
      end
      while (moveDone !== 1'b1 && n < 40);
      `CHK("move done", 1'b1, moveDone)
   endtask
   task test_done;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   ////////////////////////////////////////
   initial
   begin
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      @(negedge clk);
      `CHK("config", 8'h03, extMemConfigReg)
      `CHK("page", 8'h00, pageSelectReg)
      wr_reg(0, 8'hff);
      @(negedge clk);
      `CHK("config mask", 8'h5f, extMemConfigReg)
      $display("test registers done");
      wr_reg(0, 8'h00);
      wr_reg(1, 8'h10);
      move(0, 0, 16'h0005, 8'h00);
      `CHK("onchip cycles", 2, n)
      `CHK("int8 addr", 16'h0005, oa)
      @(posedge clk) bigRam <= 1'b1;
      move(0, 1, 16'h2abc, 8'h00);
      `CHK("int16 addr", 16'h0abc, oa)
      $display("test internal done");
      for (int k = 0; k < 4; k++)
      begin
         wr_reg(0, {6'h03, k[1:0]});
         move(1, 1, 16'h0230 + k, 8'ha0 + k);
         `CHK("mux cycles", 2 * k + 8, n)
         `CHK("mux addr", 16'h0230 + k, lastAddr)
         `CHK("ext route", 1'b0, sel)
         move(0, 1, 16'h0230 + k, 8'h00);
         `CHK("mux rdata", 8'ha0 + k, moveRData)
      end
      $display("test muxed done");
      wr_reg(0, 8'h1c);
      wr_reg(1, 8'h05);
      move(1, 0, 16'h0034, 8'h5a);
      `CHK("sep cycles", 6, n)
      `CHK("ext8 addr", 16'h7734, lastAddr)
      $display("test separate done");
      wr_reg(0, 8'h18);
      wr_reg(1, 8'h40);
      move(1, 0, 16'h0012, 8'h3c);
      `CHK("bank addr", 16'h4012, lastAddr)
      wr_reg(1, 8'h1f);
      move(0, 0, 16'h00ff, 8'h00);
      `CHK("bank on", 1'b1, sel)
      move(1, 1, 16'h2000, 8'h11);
      `CHK("bank 8k", 1'b0, sel)
      $display("test bank done");
      @(posedge clk) bigRam <= 1'b0;
      wr_reg(0, 8'h14);
      move(1, 1, 16'h0800, 8'h22);
      `CHK("size edge", 1'b0, sel)
      `CHK("split16 addr", 16'h0800, lastAddr)
      move(0, 1, 16'h07ff, 8'h00);
      `CHK("below size", 1'b1, sel)
      wr_reg(1, 8'h09);
      move(1, 0, 16'h0066, 8'h33);
      `CHK("split8 off", 1'b0, sel)
      `CHK("split8 addr", 16'h7766, lastAddr)
      // Clock enable low must freeze the page register
      @(posedge clk) clkEn <= 1'b0;
      wr_reg(1, 8'h55);
      @(negedge clk);
      `CHK("frozen page", 8'h09, pageSelectReg)
      @(posedge clk) clkEn <= 1'b1;
      $display("test split done");
      test_done;
   end
   // Watchdog well beyond the few hundred cycles the tests need
   initial
   begin
      #50000;
      fails++;
      test_done;
   end
endmodule // test_emi_ext_mem_if
